// [pkg/isc_defines.svh]
// Offsets, bit positions, masks, widths and constants of the interrupt status collector.
`ifndef ISC_DEFINES_SVH
`define ISC_DEFINES_SVH

`define ISC_ADDR_W           8
`define ISC_OFS_STATUS       8'h58
`define ISC_OFS_ENABLE       8'h5C
`define ISC_OFS_BYTE_TEST    8'h64
`define ISC_BYTE_TEST_VALUE  32'h87654321
`define ISC_ZERO_WORD        32'h00000000

`define ISC_BIT_SOFTWARE     31
`define ISC_BIT_TX_HALTED    25
`define ISC_BIT_RX_HALTED    24
`define ISC_BIT_DROP_MID     23
`define ISC_BIT_LOADED       21
`define ISC_BIT_RX_DMA       20
`define ISC_BIT_TIMER        19
`define ISC_BIT_PHY          18
`define ISC_BIT_POWER        17
`define ISC_BIT_TS_OVERFLOW  16
`define ISC_BIT_OVERSIZE     15
`define ISC_BIT_RX_ERROR     14
`define ISC_BIT_TX_ERROR     13
`define ISC_BIT_TD_UNDERRUN  11
`define ISC_BIT_TD_OVERRUN   10
`define ISC_BIT_TD_SPACE     9
`define ISC_BIT_TS_FULL      8
`define ISC_BIT_TS_LEVEL     7
`define ISC_BIT_DROPPED      6
`define ISC_BIT_RD_LEVEL     5
`define ISC_BIT_RS_FULL      4
`define ISC_BIT_RS_LEVEL     3
`define ISC_BIT_PIN_HI       2
`define ISC_BIT_PIN_LO       0

`define ISC_W1C_MASK         32'h83BBEFFF
`define ISC_ENABLE_MASK      32'h83BFEFFF
`define ISC_EDGE_MASK        32'h038003B8
`define ISC_OVERSIZE_BYTES   14'h0800
`define ISC_FRAME_LEN_W      14
`define ISC_LEVEL_W          8

`endif

// [pkg/isc_pkg.sv]
// Types shared by the interrupt status collector modules.
package isc_pkg;
`include "isc_defines.svh"

	typedef logic [31:0] isc_word_type;

	typedef struct packed {
		isc_word_type status;
		isc_word_type enable;
		isc_word_type rdata;
		logic         irq_active;
		logic         power_irq;
		logic         wake;
	} isc_top_state_type;

	typedef struct packed {
		isc_word_type prev;
	} isc_shaper_state_type;

endpackage : isc_pkg

// [pkg/isc_event_if.sv]
// Carrier of raw event conditions and the set strobes derived from them.
`timescale 1ns/1ps
interface isc_event_if;
	logic [31:0] raw;
	logic [31:0] set;
	modport shaper (input raw, output set);
	modport collector (output raw, input set);
endinterface : isc_event_if

// [core/isc_event_shaper.sv]
// Turns level conditions into one-cycle set strobes; pulse sources pass straight through.
`timescale 1ns/1ps
`include "isc_defines.svh"
module isc_event_shaper
	import isc_pkg::*;
(
	input  wire logic clock,
	input  wire logic rst,
	isc_event_if.shaper ev
);
	isc_shaper_state_type s_q;
	isc_shaper_state_type s_d;
	isc_word_type         edge_mask;

	assign edge_mask = `ISC_EDGE_MASK;

	always_comb begin
		s_d      = s_q;
		s_d.prev = ev.raw;
	end

	// Level sources latch only on their rising edge, so a flag cleared while the
	// condition still holds stays clear until the condition returns.
	genvar b;
	generate
		for (b = 0; b < 32; b++) begin : g_bit
			assign ev.set[b] = edge_mask[b] ? (ev.raw[b] & ~s_q.prev[b]) : ev.raw[b];
		end
	endgenerate

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	rise_strobe_a: assert property (@(posedge clock) disable iff (rst)
		(ev.raw[`ISC_BIT_DROP_MID] && !$past(ev.raw[`ISC_BIT_DROP_MID]))
		|-> ev.set[`ISC_BIT_DROP_MID])
		else $error("Rising level condition gave no set strobe.");
endmodule : isc_event_shaper

// [core/isc_collector.sv]
// Interrupt status collector: sticky event flags, enable mask and master indication.
//
// How it works
// - Writing one clears a flag; zero keeps it.
// - Software flag sets when its enable rises.
// - Halt request plus halted transmitter sets bit 25.
// - Halted receive engine sets bit 24.
// - Drop counter top bit rising sets bit 23.
// - Notify buffer fully loaded sets bit 21.
// - Receive DMA count drained sets bit 20.
// - Timer wrap to all ones sets bit 19.
// - Bit 18 follows phy event, read-only.
// - Power event sets bit 17, pin independent.
// - Only byte-test writes wake the device.
// - Power flag bypasses the deassertion interval.
// - Push into full status FIFO sets 16.
// - Frame over 2048 bytes sets bit 15.
// - Receive error bit 14, transmit error 13.
// - Transmit data underrun sets bit 11.
// - Write into full data FIFO sets 10.
// - Free space above threshold sets bit 9.
// - Status FIFOs full set bits 8, 4.
// - Level thresholds set bits 7, 5, 3.
// - Every dropped frame sets bit 6.
// - Pin events latch into bits 2..0.
// - Flags record events regardless of mask.
// - Master indication: any enabled flag set.
`timescale 1ns/1ps
`include "isc_defines.svh"
module isc_collector
	import isc_pkg::*;
(
	input  wire logic                        clock,
	input  wire logic                        rst,
	input  wire logic [`ISC_ADDR_W-1:0]      bus_addr,
	input  wire logic [31:0]                 bus_wdata,
	input  wire logic                        bus_write,
	input  wire logic                        bus_read,
	output logic      [31:0]                 bus_rdata,
	output logic                             irq_active,
	output logic                             power_irq,
	output logic                             wake_request,
	input  wire logic                        tx_halt_request,
	input  wire logic                        tx_halted,
	input  wire logic                        rx_halted,
	input  wire logic                        drop_count_msb,
	input  wire logic                        tx_buffer_loaded,
	input  wire logic                        completion_notify_request,
	input  wire logic                        rx_dma_done,
	input  wire logic                        timer_wrap,
	input  wire logic                        phy_event,
	input  wire logic                        power_event,
	input  wire logic                        tx_status_push,
	input  wire logic                        tx_status_full,
	input  wire logic                        rx_frame_done,
	input  wire logic [`ISC_FRAME_LEN_W-1:0] rx_frame_bytes,
	input  wire logic                        rx_error,
	input  wire logic                        tx_error,
	input  wire logic                        tx_data_underrun,
	input  wire logic                        tx_data_write,
	input  wire logic                        tx_data_full,
	input  wire logic [`ISC_LEVEL_W-1:0]     tx_free_blocks,
	input  wire logic [`ISC_LEVEL_W-1:0]     tx_avail_level,
	input  wire logic [`ISC_LEVEL_W-1:0]     tx_status_used,
	input  wire logic [`ISC_LEVEL_W-1:0]     tx_status_level,
	input  wire logic [`ISC_LEVEL_W-1:0]     rx_data_free,
	input  wire logic [`ISC_LEVEL_W-1:0]     rx_data_level,
	input  wire logic [`ISC_LEVEL_W-1:0]     rx_status_used,
	input  wire logic [`ISC_LEVEL_W-1:0]     rx_status_level,
	input  wire logic                        rx_status_full,
	input  wire logic                        frame_dropped,
	input  wire logic [2:0]                  pin_events
);
	isc_top_state_type s_q;
	isc_top_state_type s_d;
	isc_event_if       ev ();
	logic              wr_status;
	logic              wr_enable;
	logic              wr_byte_test;
	logic              sw_rise;
	isc_word_type      pending;

	function automatic logic hit(input logic [`ISC_ADDR_W-1:0] a,
			input logic [`ISC_ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	isc_event_shaper u_shaper (
		.clock (clock),
		.rst   (rst),
		.ev    (ev)
	);

	assign wr_status    = bus_write && hit(bus_addr, `ISC_OFS_STATUS);
	assign wr_enable    = bus_write && hit(bus_addr, `ISC_OFS_ENABLE);
	assign wr_byte_test = bus_write && hit(bus_addr, `ISC_OFS_BYTE_TEST);
	// Only a 0 to 1 change of the enable raises the software flag.
	assign sw_rise      = wr_enable && bus_wdata[`ISC_BIT_SOFTWARE]
		&& !s_q.enable[`ISC_BIT_SOFTWARE];
	assign pending      = s_q.status & s_q.enable;

	always_comb begin
		ev.raw = '0;
		ev.raw[`ISC_BIT_SOFTWARE]    = sw_rise;
		ev.raw[`ISC_BIT_TX_HALTED]   = tx_halt_request && tx_halted;
		ev.raw[`ISC_BIT_RX_HALTED]   = rx_halted;
		ev.raw[`ISC_BIT_DROP_MID]    = drop_count_msb;
		ev.raw[`ISC_BIT_LOADED]      = tx_buffer_loaded && completion_notify_request;
		ev.raw[`ISC_BIT_RX_DMA]      = rx_dma_done;
		ev.raw[`ISC_BIT_TIMER]       = timer_wrap;
		ev.raw[`ISC_BIT_POWER]       = power_event;
		ev.raw[`ISC_BIT_TS_OVERFLOW] = tx_status_push && tx_status_full;
		ev.raw[`ISC_BIT_OVERSIZE]    = rx_frame_done
			&& (rx_frame_bytes > `ISC_OVERSIZE_BYTES);
		ev.raw[`ISC_BIT_RX_ERROR]    = rx_error;
		ev.raw[`ISC_BIT_TX_ERROR]    = tx_error;
		ev.raw[`ISC_BIT_TD_UNDERRUN] = tx_data_underrun;
		ev.raw[`ISC_BIT_TD_OVERRUN]  = tx_data_write && tx_data_full;
		ev.raw[`ISC_BIT_TD_SPACE]    = tx_free_blocks > tx_avail_level;
		ev.raw[`ISC_BIT_TS_FULL]     = tx_status_full;
		ev.raw[`ISC_BIT_RS_FULL]     = rx_status_full;
		ev.raw[`ISC_BIT_TS_LEVEL]    = tx_status_used > tx_status_level;
		ev.raw[`ISC_BIT_RD_LEVEL]    = rx_data_free < rx_data_level;
		ev.raw[`ISC_BIT_RS_LEVEL]    = rx_status_used > rx_status_level;
		ev.raw[`ISC_BIT_DROPPED]     = frame_dropped;
		ev.raw[`ISC_BIT_PIN_HI:`ISC_BIT_PIN_LO] = pin_events;
	end

	always_comb begin
		s_d = s_q;
		// A set in the same cycle as its clear wins, so no event is lost.
		// The mask plays no part here: flags record every event.
		s_d.status = (s_q.status & ~(wr_status ? bus_wdata : `ISC_ZERO_WORD))
			| ev.set;
		s_d.status = s_d.status & `ISC_W1C_MASK;
		s_d.status[`ISC_BIT_PHY] = phy_event;
		if (wr_enable) begin
			s_d.enable = bus_wdata & `ISC_ENABLE_MASK;
		end
		s_d.rdata = `ISC_ZERO_WORD;
		if (bus_read) begin
			case (bus_addr)
				`ISC_OFS_STATUS:    s_d.rdata = s_q.status;
				`ISC_OFS_ENABLE:    s_d.rdata = s_q.enable;
				`ISC_OFS_BYTE_TEST: s_d.rdata = `ISC_BYTE_TEST_VALUE;
				default:            s_d.rdata = `ISC_ZERO_WORD;
			endcase
		end
		s_d.irq_active = |pending;
		// This path never passes through the deassertion interval timer.
		s_d.power_irq  = pending[`ISC_BIT_POWER];
		// Power events are deliberately absent from the wake term.
		s_d.wake       = wr_byte_test;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign bus_rdata    = s_q.rdata;
	assign irq_active   = s_q.irq_active;
	assign power_irq    = s_q.power_irq;
	assign wake_request = s_q.wake;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	clear_on_one_a: assert property (
		wr_status |=> ((s_q.status & $past(bus_wdata & ~ev.set & `ISC_W1C_MASK)) == 32'h0))
		else $error("Written one did not clear its flag.");

	keep_on_zero_a: assert property (
		1'b1 |=> ((($past(s_q.status) & `ISC_W1C_MASK)
			& ~($past(wr_status) ? $past(bus_wdata) : 32'h0) & ~s_q.status) == 32'h0))
		else $error("Flag dropped without a clearing write.");

	reserved_zero_a: assert property (
		(s_q.status & ~(`ISC_W1C_MASK | 32'h00040000)) == 32'h0)
		else $error("Reserved status bit set.");

	software_set_a: assert property (
		(wr_enable && bus_wdata[31] && !s_q.enable[31]) |=> s_q.status[31])
		else $error("Software flag not set by enable rising.");

	tx_halt_set_a: assert property (
		$rose(tx_halt_request && tx_halted) |=> s_q.status[25])
		else $error("Transmit halt flag not set.");

	rx_halt_set_a: assert property (
		$rose(rx_halted) |=> s_q.status[24])
		else $error("Receive halt flag not set.");

	loaded_set_a: assert property (
		(tx_buffer_loaded && completion_notify_request) |=> s_q.status[21])
		else $error("Loaded notify flag not set.");

	phy_follow_a: assert property (
		1'b1 |=> (s_q.status[18] == $past(phy_event)))
		else $error("Phy flag does not follow its source.");

	power_no_wake_a: assert property (
		(power_event && !wr_byte_test) |=> (s_q.status[17] && !wake_request))
		else $error("Power event mishandled.");

	wake_pulse_a: assert property (
		(bus_write && (bus_addr == `ISC_OFS_BYTE_TEST)) |=> wake_request)
		else $error("Wake request missing after byte-test write.");

	wake_only_a: assert property (
		!(bus_write && (bus_addr == `ISC_OFS_BYTE_TEST)) |=> !wake_request)
		else $error("Wake request without a byte-test write.");

	power_direct_a: assert property (
		(s_q.status[17] && s_q.enable[17]) |=> power_irq)
		else $error("Power flag did not reach output at once.");

	overflow_set_a: assert property (
		(tx_status_push && tx_status_full) |=> s_q.status[16])
		else $error("Status overflow flag not set.");

	oversize_set_a: assert property (
		(rx_frame_done && rx_frame_bytes > 14'd2048) |=> s_q.status[15])
		else $error("Oversize frame flag not set.");

	overrun_set_a: assert property (
		(tx_data_write && tx_data_full) |=> s_q.status[10])
		else $error("Data overrun flag not set.");

	masked_record_a: assert property (
		(frame_dropped && !s_q.enable[6]) |=> s_q.status[6])
		else $error("Masked event not recorded.");

	master_irq_a: assert property (
		1'b1 |=> (irq_active == |($past(s_q.status) & $past(s_q.enable))))
		else $error("Master indication wrong.");

	read_status_a: assert property (
		(bus_read && hit(bus_addr, `ISC_OFS_STATUS)) |=> (bus_rdata == $past(s_q.status))
			##1 (bus_rdata == 32'h0 || $past(bus_read)))
		else $error("Status read data wrong or held too long.");

	set_wins_a: assert property (
		wr_status |=> ((s_q.status & $past(ev.set & `ISC_W1C_MASK))
			== $past(ev.set & `ISC_W1C_MASK)))
		else $error("Clearing write swallowed a same-cycle event.");

	software_only_a: assert property (
		(!(wr_enable && bus_wdata[`ISC_BIT_SOFTWARE]) && !s_q.status[`ISC_BIT_SOFTWARE])
		|=> !s_q.status[`ISC_BIT_SOFTWARE])
		else $error("Software flag set without its enable.");

	halt_partial_a: assert property (
		(!tx_halt_request && !s_q.status[`ISC_BIT_TX_HALTED])
		|=> !s_q.status[`ISC_BIT_TX_HALTED])
		else $error("Transmit halt flag set without a halt request.");

	drop_mid_set_a: assert property (
		$rose(drop_count_msb) |=> s_q.status[`ISC_BIT_DROP_MID])
		else $error("Drop counter midpoint flag not set.");

	notify_gate_a: assert property (
		(!completion_notify_request && !s_q.status[`ISC_BIT_LOADED])
		|=> !s_q.status[`ISC_BIT_LOADED])
		else $error("Loaded flag set without a notify request.");

	dma_done_set_a: assert property (
		rx_dma_done |=> s_q.status[`ISC_BIT_RX_DMA])
		else $error("Receive DMA flag not set.");

	timer_wrap_set_a: assert property (
		timer_wrap |=> s_q.status[`ISC_BIT_TIMER])
		else $error("Timer wrap flag not set.");

	phy_write_kept_a: assert property (
		(wr_status && bus_wdata[`ISC_BIT_PHY]) |=> (s_q.status[`ISC_BIT_PHY] == $past(phy_event)))
		else $error("Host write changed the phy flag.");

	power_clear_a: assert property (
		(wr_status && bus_wdata[`ISC_BIT_POWER] && !power_event)
		|=> !s_q.status[`ISC_BIT_POWER])
		else $error("Power flag not cleared by a written one.");

	power_drop_a: assert property (
		!(s_q.status[`ISC_BIT_POWER] && s_q.enable[`ISC_BIT_POWER]) |=> !power_irq)
		else $error("Power output high without an enabled flag.");

	undersize_clear_a: assert property (
		(rx_frame_done && (rx_frame_bytes <= `ISC_OVERSIZE_BYTES)
			&& !s_q.status[`ISC_BIT_OVERSIZE]) |=> !s_q.status[`ISC_BIT_OVERSIZE])
		else $error("Oversize flag set by a frame that is not too long.");

	rx_error_set_a: assert property (
		rx_error |=> s_q.status[`ISC_BIT_RX_ERROR])
		else $error("Receive error flag not set.");

	tx_error_set_a: assert property (
		tx_error |=> s_q.status[`ISC_BIT_TX_ERROR])
		else $error("Transmit error flag not set.");

	underrun_set_a: assert property (
		tx_data_underrun |=> s_q.status[`ISC_BIT_TD_UNDERRUN])
		else $error("Data underrun flag not set.");

	overrun_gate_a: assert property (
		(!(tx_data_write && tx_data_full) && !s_q.status[`ISC_BIT_TD_OVERRUN])
		|=> !s_q.status[`ISC_BIT_TD_OVERRUN])
		else $error("Data overrun flag set without a write into a full FIFO.");

	space_rise_set_a: assert property (
		$rose(tx_free_blocks > tx_avail_level) |=> s_q.status[`ISC_BIT_TD_SPACE])
		else $error("Space available flag not set.");

	ts_full_set_a: assert property (
		$rose(tx_status_full) |=> s_q.status[`ISC_BIT_TS_FULL])
		else $error("Transmit status full flag not set.");

	rs_full_set_a: assert property (
		$rose(rx_status_full) |=> s_q.status[`ISC_BIT_RS_FULL])
		else $error("Receive status full flag not set.");

	ts_level_set_a: assert property (
		$rose(tx_status_used > tx_status_level) |=> s_q.status[`ISC_BIT_TS_LEVEL])
		else $error("Transmit status level flag not set.");

	rd_level_set_a: assert property (
		$rose(rx_data_free < rx_data_level) |=> s_q.status[`ISC_BIT_RD_LEVEL])
		else $error("Receive data level flag not set.");

	rs_level_set_a: assert property (
		$rose(rx_status_used > rx_status_level) |=> s_q.status[`ISC_BIT_RS_LEVEL])
		else $error("Receive status level flag not set.");

	dropped_set_a: assert property (
		frame_dropped |=> s_q.status[`ISC_BIT_DROPPED])
		else $error("Dropped frame flag not set.");

	pin_set_a: assert property (
		(|pin_events) |=> ((s_q.status[`ISC_BIT_PIN_HI:`ISC_BIT_PIN_LO] & $past(pin_events))
			== $past(pin_events)))
		else $error("Pin event not latched.");

	enable_hold_a: assert property (
		!wr_enable |=> (s_q.enable == $past(s_q.enable)))
		else $error("Enable mask changed without a write.");
endmodule : isc_collector

// [core/isc_collector_note.sv]
// Holds no logic: the collector and its event shaper make up the whole block.

// [test/isc_host_model.sv]
// Host processor model that runs single-word register cycles on the plain bus port.
`timescale 1ns/1ps
`include "isc_defines.svh"
module isc_host_model
	import isc_pkg::*;
(
	input  wire logic                   clock,
	output logic     [`ISC_ADDR_W-1:0]  bus_addr,
	output isc_word_type                bus_wdata,
	output logic                        bus_write,
	output logic                        bus_read,
	input  wire isc_word_type           bus_rdata
);
	initial begin
		bus_addr = 8'h00;
		bus_wdata = 32'h0;
		bus_write = 1'b0;
		bus_read = 1'b0;
	end

	// Idle write data is inverted so a stale word never passes for a live one.
	task automatic wr(input logic [`ISC_ADDR_W-1:0] a, input isc_word_type d);
		@(posedge clock);
		bus_addr <= a;
		bus_wdata <= d;
		bus_write <= 1'b1;
		@(posedge clock);
		bus_write <= 1'b0;
		bus_wdata <= ~d;
	endtask : wr

	task automatic rd(input logic [`ISC_ADDR_W-1:0] a, output isc_word_type d);
		@(posedge clock);
		bus_addr <= a;
		bus_read <= 1'b1;
		@(posedge clock);
		bus_read <= 1'b0;
		#1 d = bus_rdata;
	endtask : rd
endmodule : isc_host_model

// [test/testbench.sv]
// Self-checking bench for the interrupt status collector.
`timescale 1ns/1ps
`include "isc_defines.svh"
module testbench
	import isc_pkg::*;
;
	logic	clock, rst, bus_write, bus_read, irq_active, power_irq, wake_request;
	logic	[`ISC_ADDR_W-1:0] bus_addr;
	isc_word_type	bus_wdata, bus_rdata, pv, rd_v;
	logic	tx_halt_request, tx_halted, rx_halted, drop_count_msb, tx_buffer_loaded;
	logic	completion_notify_request, phy_event, tx_status_push, tx_status_full;
	logic	rx_frame_done, rx_status_full, tx_data_write, tx_data_full;
	logic	[`ISC_FRAME_LEN_W-1:0] rx_frame_bytes;
	logic	[`ISC_LEVEL_W-1:0] tx_free_blocks, tx_avail_level, tx_status_used, tx_status_level;
	logic	[`ISC_LEVEL_W-1:0] rx_data_free, rx_data_level, rx_status_used, rx_status_level;
	logic	rx_dma_done, timer_wrap, power_event, rx_error, tx_error, tx_data_underrun;
	logic	frame_dropped;
	logic	[2:0] pin_events;
	int	error_cnt, total_checks;

	assign {rx_dma_done, timer_wrap, power_event} = {pv[20], pv[19], pv[17]};
	assign {rx_error, tx_error, tx_data_underrun} = {pv[14], pv[13], pv[11]};
	assign frame_dropped = pv[6];
	assign pin_events = pv[2:0];

	isc_host_model host_u (.clock, .bus_addr, .bus_wdata, .bus_write, .bus_read, .bus_rdata);
	isc_collector dut_u (.clock, .rst, .bus_addr, .bus_wdata, .bus_write, .bus_read, .bus_rdata,
		.irq_active, .power_irq, .wake_request, .tx_halt_request, .tx_halted, .rx_halted,
		.drop_count_msb, .tx_buffer_loaded, .completion_notify_request, .rx_dma_done,
		.timer_wrap, .phy_event, .power_event, .tx_status_push, .tx_status_full,
		.rx_frame_done, .rx_frame_bytes, .rx_error, .tx_error, .tx_data_underrun,
		.tx_data_write, .tx_data_full, .tx_free_blocks, .tx_avail_level, .tx_status_used,
		.tx_status_level, .rx_data_free, .rx_data_level, .rx_status_used, .rx_status_level,
		.rx_status_full, .frame_dropped, .pin_events);

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish

	task automatic chk_word(input string what, input isc_word_type exp, input isc_word_type got);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_word

	task automatic chk_bit(input string what, input logic exp, input logic got);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %b seen %b", what, exp, got);
		end
	endtask : chk_bit

	task automatic reg_is(input string what, input logic [7:0] a, input isc_word_type exp);
		host_u.rd(a, rd_v);
		chk_word(what, exp, rd_v);
	endtask : reg_is

	task automatic pulse(input isc_word_type m);
		@(posedge clock);
		pv <= m;
		@(posedge clock);
		pv <= 32'h0;
	endtask : pulse

	// The outputs lag the status by a cycle, so a short bounded wait is allowed here.
	task automatic wait_out(input string what, input int sel, input logic val);
		logic seen;
		for (int i = 0; i < 4; i++) begin
			@(posedge clock);
			#1 seen = sel ? power_irq : irq_active;
			if (seen === val)
				break;
		end
		chk_bit(what, val, seen);
		if (seen !== val)
			tally_and_finish();
	endtask : wait_out

	task automatic idle_levels();
		{tx_halt_request, tx_halted, rx_halted, drop_count_msb, tx_buffer_loaded, phy_event,
			completion_notify_request, tx_status_push, tx_status_full, rx_frame_done,
			rx_status_full, tx_data_write, tx_data_full} <= '0;
		rx_frame_bytes <= 14'h0000;
		{tx_free_blocks, tx_avail_level, tx_status_used, tx_status_level} <= 32'h0;
		{rx_data_free, rx_data_level, rx_status_used, rx_status_level} <= 32'h0;
	endtask : idle_levels

	task automatic reset_values();
		#1 chk_bit("irq after reset", 1'b0, irq_active);
		chk_bit("power irq after reset", 1'b0, power_irq);
		chk_bit("wake after reset", 1'b0, wake_request);
		reg_is("status reset", `ISC_OFS_STATUS, 32'h0);
		reg_is("enable reset", `ISC_OFS_ENABLE, 32'h0);
		reg_is("byte test", `ISC_OFS_BYTE_TEST, `ISC_BYTE_TEST_VALUE);
		host_u.wr(8'h60, 32'hFFFFFFFF);
		reg_is("unmapped", 8'h60, 32'h0);
		reg_is("status quiet", `ISC_OFS_STATUS, 32'h0);
	endtask : reset_values

	task automatic pulse_sources();
		int bits[10] = '{20, 19, 17, 14, 13, 11, 6, 2, 1, 0};
		isc_word_type m;
		foreach (bits[i]) begin
			m = 32'h1 << bits[i];
			pulse(m);
			reg_is("event flag", `ISC_OFS_STATUS, m);
			host_u.wr(`ISC_OFS_STATUS, ~m);
			reg_is("zero write", `ISC_OFS_STATUS, m);
			host_u.wr(`ISC_OFS_STATUS, m);
			reg_is("one write", `ISC_OFS_STATUS, 32'h0);
		end
	endtask : pulse_sources

	// First every qualifier is missing or at the boundary, then each condition is completed.
	task automatic level_sources();
		@(posedge clock);
		{tx_halted, tx_buffer_loaded, tx_status_push, tx_data_write, rx_frame_done} <= '1;
		rx_frame_bytes <= 14'h0800;
		{tx_free_blocks, tx_avail_level} <= 16'h1010;
		@(posedge clock);
		{tx_buffer_loaded, tx_status_push, tx_data_write, rx_frame_done} <= '0;
		reg_is("partial conditions", `ISC_OFS_STATUS, 32'h0);
		@(posedge clock);
		{tx_halt_request, rx_halted, drop_count_msb, completion_notify_request, tx_buffer_loaded,
			tx_status_full, tx_status_push, tx_data_full, tx_data_write, rx_frame_done,
			rx_status_full} <= '1;
		rx_frame_bytes <= 14'h0801;
		{tx_free_blocks, tx_status_used, rx_data_level, rx_status_used} <= 32'h11010101;
		@(posedge clock);
		{tx_buffer_loaded, tx_status_push, tx_data_write, rx_frame_done} <= '0;
		reg_is("level flags", `ISC_OFS_STATUS, 32'h03A187B8);
		host_u.wr(`ISC_OFS_STATUS, 32'h03A187B8);
		reg_is("level cleared", `ISC_OFS_STATUS, 32'h0);
		@(posedge clock);
		idle_levels();
	endtask : level_sources

	task automatic phy_readonly();
		@(posedge clock);
		phy_event <= 1'b1;
		reg_is("phy flag", `ISC_OFS_STATUS, 32'h00040000);
		host_u.wr(`ISC_OFS_STATUS, 32'h00040000);
		reg_is("phy write", `ISC_OFS_STATUS, 32'h00040000);
		@(posedge clock);
		phy_event <= 1'b0;
		reg_is("phy gone", `ISC_OFS_STATUS, 32'h0);
	endtask : phy_readonly

	task automatic mask_and_master();
		host_u.wr(`ISC_OFS_ENABLE, 32'h80004000);
		reg_is("software flag", `ISC_OFS_STATUS, 32'h80000000);
		wait_out("irq", 0, 1'b1);
		host_u.wr(`ISC_OFS_STATUS, 32'h80000000);
		reg_is("software clear", `ISC_OFS_STATUS, 32'h0);
		wait_out("irq", 0, 1'b0);
		pulse(32'h00004000);
		wait_out("irq", 0, 1'b1);
		host_u.wr(`ISC_OFS_STATUS, 32'h00004000);
		host_u.wr(`ISC_OFS_ENABLE, 32'hFFFFFFFF);
		reg_is("enable mask", `ISC_OFS_ENABLE, `ISC_ENABLE_MASK);
		host_u.wr(`ISC_OFS_ENABLE, 32'h00020000);
		pulse(32'h00020000);
		wait_out("power irq", 1, 1'b1);
		chk_bit("wake", 1'b0, wake_request);
		host_u.wr(`ISC_OFS_STATUS, 32'h00020000);
		wait_out("power irq", 1, 1'b0);
	endtask : mask_and_master

	task automatic wake_on_write();
		host_u.wr(`ISC_OFS_BYTE_TEST, 32'h0);
		#1 chk_bit("wake pulse", 1'b1, wake_request);
		@(posedge clock);
		#1 chk_bit("wake end", 1'b0, wake_request);
		reg_is("byte test kept", `ISC_OFS_BYTE_TEST, `ISC_BYTE_TEST_VALUE);
	endtask : wake_on_write

	initial begin
		error_cnt = 0;
		total_checks = 0;
		rst = 1'b1;
		pv = 32'h0;
		idle_levels();
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		reset_values();
		pulse_sources();
		level_sources();
		phy_readonly();
		mask_and_master();
		wake_on_write();
		tally_and_finish();
	end
endmodule : testbench
